// *** rtl/hbiu_pkg.sv ***
// hbiu_pkg: constants and types of the host bus interface unit
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package hbiu_pkg;

    // lane select patterns, active low, lane 3 in bit 3
    localparam logic [3:0] LANES_WORD = 4'h0;
    localparam logic [3:0] LANES_LOW_HALF = 4'hC;
    localparam logic [3:0] LANES_HIGH_HALF = 4'h3;
    localparam logic [3:0] LANES_BYTE0 = 4'hE;
    localparam logic [3:0] LANES_BYTE1 = 4'hD;
    localparam logic [3:0] LANES_BYTE2 = 4'hB;
    localparam logic [3:0] LANES_BYTE3 = 4'h7;

    // access size codes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_BAD = 2'h3;

    // queue data register location
    localparam logic [2:0] QUEUE_OFFSET = 3'h0;

    // reset values
    localparam logic [14:0] ADDR_RST = 15'h0000;
    localparam logic [3:0] LANES_RST = 4'hF;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;

    // synchroniser width: read strobe, write strobe, strap
    localparam int SYNC_W = 3;
    localparam int SYNC_RD = 0;
    localparam int SYNC_WR = 1;
    localparam int SYNC_STRAP = 2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_A_BUSY = 3'b001,
        ST_A_END = 3'b010,
        ST_V_BUSY = 3'b011,
        ST_V_DONE = 3'b100,
        ST_B_BUSY = 3'b101,
        ST_B_DONE = 3'b110
    } hbiu_state_t;

endpackage
`default_nettype wire

// *** rtl/hbiu_sync.sv ***
// hbiu_sync: two flip-flop synchroniser for a group of pin levels
// assumes each bit is a level, independent of the others
`timescale 1ns/1ps
`default_nettype none
module hbiu_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pinIn,
    input wire logic [WIDTH-1:0] rstVal,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] hold_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_ff <= rstVal;
            hold_ff <= rstVal;
        end else begin
            meta_ff <= pinIn;
            hold_ff <= meta_ff;
        end
    end

    assign syncOut = hold_ff;

endmodule // hbiu_sync
`default_nettype wire

// *** rtl/hbiu_host_port.sv ***
// hbiu_host_port: host bus interface unit, async strobes plus bus-clock cycles
// assumes clk_sys is the bus clock and the core answers requests with reqAck
// Operation
// - queue select bypasses the decoder and makes a 32-bit data register access
// - strap low picks local-bus single cycles, high picks burst cycles
// - local-bus mode samples direction when the cycle qualifier asserts
// - local-bus direction high means write, low means read
// - burst mode: direction is burst read, qualifier is burst write
// - burst mode: sync ready asserted as wait while transfer cannot finish
// - burst mode: ready-return low from host extends the transfer
// - async wait output held low on reads until the core answers; writes never wait
// - address, space enable and lanes latched on address strobe rising edge
// - target hit is a combinational decode of space enable and A[15:4]
// - async strobes give single transfers only, never bursts
// - strobe tied low keeps address live; write data taken at write strobe end
// - queue select ignores lanes and reaches only the data register
// - local-bus mode does single transfers, selected only by local decode
// - local-bus: sync ready ends cycle; read data held until ready-return
// - decoding enabled only while address space enable is low
// - lane patterns select word, half or byte access
// - synchronous accesses timed on the bus clock, up to 50 MHz
`timescale 1ns/1ps
`default_nettype none
module hbiu_host_port (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:1] addrIn,
    input wire logic addrSpaceEnable,
    input wire logic lane0SelN,
    input wire logic lane1SelN,
    input wire logic lane2SelN,
    input wire logic lane3SelN,
    input wire logic addrStrobeN,
    input wire logic queuePortSelectN,
    input wire logic [15:4] baseAddr,
    output logic localTargetHitN,
    input wire logic syncStyleStrap,
    input wire logic cycleQualifierN,
    input wire logic syncDir,
    output logic syncReadyN,
    input wire logic readyReturnN,
    input wire logic asyncRdN,
    input wire logic asyncWrN,
    output logic asyncWaitN,
    input wire logic [31:0] dataIn,
    output logic [31:0] dataOut,
    output logic dataOe,
    output logic reqValid,
    output logic reqWrite,
    output logic reqQueue,
    output logic [2:0] reqOffset,
    output logic [3:0] reqLanes,
    output logic [1:0] reqSize,
    output logic [31:0] reqWrData,
    input wire logic reqAck,
    input wire logic [31:0] reqRdData
);

    ////////////////////////////////////////////////////////////////////////////
    // lane pattern to access size
    function automatic logic [1:0] laneSize(input logic [3:0] lanesN);
        unique case (lanesN)
            hbiu_pkg::LANES_WORD: laneSize = hbiu_pkg::SIZE_WORD;
            hbiu_pkg::LANES_LOW_HALF, hbiu_pkg::LANES_HIGH_HALF: laneSize = hbiu_pkg::SIZE_HALF;
            hbiu_pkg::LANES_BYTE0, hbiu_pkg::LANES_BYTE1,
            hbiu_pkg::LANES_BYTE2, hbiu_pkg::LANES_BYTE3: laneSize = hbiu_pkg::SIZE_BYTE;
            default: laneSize = hbiu_pkg::SIZE_BAD;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // strobe and strap synchronisers
    logic [hbiu_pkg::SYNC_W-1:0] syncVec;
    logic rdSync;
    logic wrSync;
    logic strapSync;

    hbiu_sync #(.WIDTH(hbiu_pkg::SYNC_W)) uSync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pinIn({syncStyleStrap, asyncWrN, asyncRdN}),
        .rstVal(3'h3),
        .syncOut(syncVec)
    );

    assign rdSync = syncVec[hbiu_pkg::SYNC_RD];
    assign wrSync = syncVec[hbiu_pkg::SYNC_WR];
    assign strapSync = syncVec[hbiu_pkg::SYNC_STRAP];

    ////////////////////////////////////////////////////////////////////////////
    // address latch, transparent while strobe low
    logic [15:1] addrLat_ff, nxt_addrLat;
    logic aenLat_ff, nxt_aenLat;
    logic [3:0] lanesLat_ff, nxt_lanesLat;
    logic [15:1] effAddr;
    logic effAen;
    logic [3:0] effLanes;
    logic hit;

    always_comb begin
        nxt_addrLat = addrLat_ff;
        nxt_aenLat = aenLat_ff;
        nxt_lanesLat = lanesLat_ff;
        if (!addrStrobeN) begin
            nxt_addrLat = addrIn;
            nxt_aenLat = addrSpaceEnable;
            nxt_lanesLat = {lane3SelN, lane2SelN, lane1SelN, lane0SelN};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            addrLat_ff <= hbiu_pkg::ADDR_RST;
            aenLat_ff <= 1'b1;
            lanesLat_ff <= hbiu_pkg::LANES_RST;
        end else begin
            addrLat_ff <= nxt_addrLat;
            aenLat_ff <= nxt_aenLat;
            lanesLat_ff <= nxt_lanesLat;
        end
    end

    assign effAddr = addrStrobeN ? addrLat_ff : addrIn;
    assign effAen = addrStrobeN ? aenLat_ff : addrSpaceEnable;
    assign effLanes = addrStrobeN ? lanesLat_ff : {lane3SelN, lane2SelN, lane1SelN, lane0SelN};
    assign hit = !effAen && (effAddr[15:4] == baseAddr);
    assign localTargetHitN = !hit;

    ////////////////////////////////////////////////////////////////////////////
    // transfer state machine
    hbiu_pkg::hbiu_state_t state_ff, nxt_state;
    logic rdPrev_ff, nxt_rdPrev;
    logic wrPrev_ff, nxt_wrPrev;
    logic reqValid_ff, nxt_reqValid;
    logic reqWrite_ff, nxt_reqWrite;
    logic reqQueue_ff, nxt_reqQueue;
    logic [2:0] reqOffset_ff, nxt_reqOffset;
    logic [3:0] reqLanes_ff, nxt_reqLanes;
    logic [31:0] reqWrData_ff, nxt_reqWrData;
    logic [31:0] rdData_ff, nxt_rdData;
    logic syncReadyN_ff, nxt_syncReadyN;
    logic asyncWaitN_ff, nxt_asyncWaitN;
    logic [31:0] wrCap_ff, nxt_wrCap;
    logic rdFall;
    logic wrFall;
    logic wrRise;
    logic asyncSel;
    logic burstRd;
    logic burstWr;

    assign rdFall = rdPrev_ff && !rdSync;
    assign wrFall = wrPrev_ff && !wrSync;
    assign wrRise = !wrPrev_ff && wrSync;
    assign asyncSel = !queuePortSelectN || hit;
    assign burstRd = !syncDir;
    assign burstWr = !cycleQualifierN;

    always_comb begin
        nxt_state = state_ff;
        nxt_rdPrev = rdSync;
        nxt_wrPrev = wrSync;
        nxt_reqValid = 1'b0;
        nxt_reqWrite = reqWrite_ff;
        nxt_reqQueue = reqQueue_ff;
        nxt_reqOffset = reqOffset_ff;
        nxt_reqLanes = reqLanes_ff;
        nxt_reqWrData = reqWrData_ff;
        nxt_rdData = rdData_ff;
        nxt_syncReadyN = syncReadyN_ff;
        nxt_asyncWaitN = asyncWaitN_ff;
        nxt_wrCap = !wrSync ? dataIn : wrCap_ff;
        unique case (state_ff)
            hbiu_pkg::ST_IDLE: begin
                nxt_reqQueue = !queuePortSelectN;
                nxt_reqOffset = !queuePortSelectN ? hbiu_pkg::QUEUE_OFFSET : effAddr[3:1];
                nxt_reqLanes = !queuePortSelectN ? hbiu_pkg::LANES_WORD : effLanes;
                if (!strapSync && !cycleQualifierN && hit) begin
                    nxt_reqValid = 1'b1;
                    nxt_reqWrite = syncDir;
                    nxt_reqQueue = 1'b0;
                    nxt_reqOffset = effAddr[3:1];
                    nxt_reqLanes = effLanes;
                    nxt_reqWrData = dataIn;
                    nxt_state = hbiu_pkg::ST_V_BUSY;
                end else if (strapSync && !queuePortSelectN && (burstRd || burstWr)) begin
                    nxt_reqValid = 1'b1;
                    nxt_reqWrite = burstWr;
                    nxt_reqWrData = dataIn;
                    nxt_syncReadyN = 1'b0;
                    nxt_state = hbiu_pkg::ST_B_BUSY;
                end else if (rdFall && asyncSel) begin
                    nxt_reqValid = 1'b1;
                    nxt_reqWrite = 1'b0;
                    nxt_asyncWaitN = 1'b0;
                    nxt_state = hbiu_pkg::ST_A_BUSY;
                end else if (wrRise && asyncSel) begin
                    nxt_reqValid = 1'b1;
                    nxt_reqWrite = 1'b1;
                    nxt_reqWrData = wrCap_ff;
                    nxt_state = hbiu_pkg::ST_A_BUSY;
                end else if (wrFall && asyncSel) begin
                    nxt_asyncWaitN = 1'b1;
                end
            end
            hbiu_pkg::ST_A_BUSY: begin
                if (reqAck) begin
                    nxt_rdData = reqWrite_ff ? rdData_ff : reqRdData;
                    nxt_asyncWaitN = 1'b1;
                    nxt_state = hbiu_pkg::ST_A_END;
                end
            end
            hbiu_pkg::ST_A_END: begin
                if (rdSync && wrSync) begin
                    nxt_state = hbiu_pkg::ST_IDLE;
                end
            end
            hbiu_pkg::ST_V_BUSY: begin
                if (reqAck) begin
                    nxt_rdData = reqWrite_ff ? rdData_ff : reqRdData;
                    nxt_syncReadyN = 1'b0;
                    nxt_state = hbiu_pkg::ST_V_DONE;
                end
            end
            hbiu_pkg::ST_V_DONE: begin
                if (!readyReturnN) begin
                    nxt_syncReadyN = 1'b1;
                    nxt_state = hbiu_pkg::ST_IDLE;
                end
            end
            hbiu_pkg::ST_B_BUSY: begin
                if (reqAck) begin
                    nxt_rdData = reqWrite_ff ? rdData_ff : reqRdData;
                    nxt_syncReadyN = 1'b1;
                    nxt_state = hbiu_pkg::ST_B_DONE;
                end
            end
            hbiu_pkg::ST_B_DONE: begin
                if (readyReturnN) begin
                    nxt_state = hbiu_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = hbiu_pkg::ST_IDLE;
                nxt_syncReadyN = 1'b1;
                nxt_asyncWaitN = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= hbiu_pkg::ST_IDLE;
            rdPrev_ff <= 1'b1;
            wrPrev_ff <= 1'b1;
            reqValid_ff <= 1'b0;
            reqWrite_ff <= 1'b0;
            reqQueue_ff <= 1'b0;
            reqOffset_ff <= hbiu_pkg::QUEUE_OFFSET;
            reqLanes_ff <= hbiu_pkg::LANES_RST;
            reqWrData_ff <= hbiu_pkg::DATA_RST;
            rdData_ff <= hbiu_pkg::DATA_RST;
            syncReadyN_ff <= 1'b1;
            asyncWaitN_ff <= 1'b1;
            wrCap_ff <= hbiu_pkg::DATA_RST;
        end else begin
            state_ff <= nxt_state;
            rdPrev_ff <= nxt_rdPrev;
            wrPrev_ff <= nxt_wrPrev;
            reqValid_ff <= nxt_reqValid;
            reqWrite_ff <= nxt_reqWrite;
            reqQueue_ff <= nxt_reqQueue;
            reqOffset_ff <= nxt_reqOffset;
            reqLanes_ff <= nxt_reqLanes;
            reqWrData_ff <= nxt_reqWrData;
            rdData_ff <= nxt_rdData;
            syncReadyN_ff <= nxt_syncReadyN;
            asyncWaitN_ff <= nxt_asyncWaitN;
            wrCap_ff <= nxt_wrCap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign reqValid = reqValid_ff;
    assign reqWrite = reqWrite_ff;
    assign reqQueue = reqQueue_ff;
    assign reqOffset = reqOffset_ff;
    assign reqLanes = reqLanes_ff;
    assign reqSize = laneSize(reqLanes_ff);
    assign reqWrData = reqWrData_ff;
    assign dataOut = rdData_ff;
    assign syncReadyN = syncReadyN_ff;
    assign asyncWaitN = asyncWaitN_ff;
    assign dataOe = !reqWrite_ff && ((state_ff == hbiu_pkg::ST_A_END && !rdSync)
        || state_ff == hbiu_pkg::ST_V_DONE
        || (state_ff == hbiu_pkg::ST_B_DONE && burstRd));

endmodule // hbiu_host_port
`default_nettype wire

// *** testbench/hbiu_host_port_chk.sv ***
// hbiu_host_port_chk: port assertions of hbiu_host_port
// assumes one clock clk_sys and a synchronous active high rst
`timescale 1ns/1ps
`default_nettype none
module hbiu_host_port_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:1] addrIn,
    input wire logic addrSpaceEnable,
    input wire logic addrStrobeN,
    input wire logic [15:4] baseAddr,
    input wire logic localTargetHitN,
    input wire logic syncStyleStrap,
    input wire logic cycleQualifierN,
    input wire logic syncDir,
    input wire logic syncReadyN,
    input wire logic readyReturnN,
    input wire logic asyncWaitN,
    input wire logic dataOe,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic reqQueue,
    input wire logic [2:0] reqOffset,
    input wire logic [3:0] reqLanes,
    input wire logic [1:0] reqSize,
    input wire logic reqAck
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    reset_idle_a: assert property ($fell(rst) |-> syncReadyN && asyncWaitN && !reqValid && !dataOe)
        else $error("outputs busy after reset");
    hit_decode_a: assert property (!addrStrobeN && !addrSpaceEnable && addrIn[15:4] == baseAddr
        |-> !localTargetHitN) else $error("target hit missing");
    space_block_a: assert property (!addrStrobeN && addrSpaceEnable |-> localTargetHitN)
        else $error("hit during memory cycle");
    single_req_a: assert property (reqValid |=> !reqValid)
        else $error("request longer than one cycle");
    queue_word_a: assert property (reqValid && reqQueue |->
        reqLanes == hbiu_pkg::LANES_WORD && reqOffset == hbiu_pkg::QUEUE_OFFSET && reqSize == hbiu_pkg::SIZE_WORD)
        else $error("queue access not a word at offset zero");
    wait_cause_a: assert property ($fell(asyncWaitN) |-> reqValid && !reqWrite)
        else $error("wait state without read request");
    lb_dir_a: assert property (reqValid && !syncStyleStrap
        && (!$past(cycleQualifierN) || !$past(cycleQualifierN, 2)) |-> reqWrite == syncDir)
        else $error("local bus direction wrong");
    lb_hold_a: assert property (!syncStyleStrap && !syncReadyN && readyReturnN
        |=> !syncReadyN && (reqWrite || dataOe)) else $error("sync ready dropped before ready return");
    burst_wait_a: assert property (syncStyleStrap && reqAck |-> ##[1:2] syncReadyN)
        else $error("burst wait not released");
    host_wait_a: assert property (syncStyleStrap && !readyReturnN |=> !reqValid)
        else $error("burst beat taken during host wait");
endmodule // hbiu_host_port_chk
bind hbiu_host_port hbiu_host_port_chk chk (.clk_sys, .rst, .addrIn, .addrSpaceEnable, .addrStrobeN, .baseAddr,
    .localTargetHitN, .syncStyleStrap, .cycleQualifierN, .syncDir, .syncReadyN, .readyReturnN, .asyncWaitN,
    .dataOe, .reqValid, .reqWrite, .reqQueue, .reqOffset, .reqLanes, .reqSize, .reqAck);
`default_nettype wire

// *** testbench/hbiu_host_model.sv ***
// hbiu_host_model: host side, drives async, local bus and burst cycles
// assumes clk_sys is the bus clock shared with the device
`timescale 1ns/1ps
`default_nettype none
module hbiu_host_model (
    input wire logic clk_sys,
    output logic [15:1] addrIn,
    output logic addrSpaceEnable,
    output logic [3:0] lanesN,
    output logic addrStrobeN,
    output logic queuePortSelectN,
    output logic cycleQualifierN,
    output logic syncDir,
    output logic readyReturnN,
    output logic asyncRdN,
    output logic asyncWrN,
    output logic [31:0] dataIn,
    input wire logic syncReadyN,
    input wire logic asyncWaitN,
    input wire logic [31:0] dataOut
);
    initial begin
        {addrIn, addrSpaceEnable, lanesN, addrStrobeN, dataIn} = '0;
        {queuePortSelectN, cycleQualifierN, syncDir, readyReturnN, asyncRdN, asyncWrN} = 6'h3F;
    end
    ////////////////////////////////////////////////////////////
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic setup(input logic [15:1] a, input logic addr_space_enable, input logic [3:0] ln, input logic qs);
        addrIn = a;
        addrSpaceEnable = addr_space_enable;
        lanesN = ln;
        queuePortSelectN = qs;
    endtask
    // single async transfer, sync inputs stay idle throughout
    task automatic asyncXfer(input logic wr, input logic [31:0] wd, output logic [31:0] rd);
        dataIn = wd;
        if (wr) asyncWrN = 1'b0;
        else asyncRdN = 1'b0;
        repeat (4) tick();
        for (int n = 0; n < 64 && asyncWaitN !== 1'b1; n++) tick();
        rd = dataOut;
        asyncRdN = 1'b1;
        asyncWrN = 1'b1;
        repeat (3) tick();
        dataIn = ~wd;
        // a write is only taken at strobe end; let its answer finish first
        repeat (4) tick();
    endtask
    // local bus single cycle, address scrambled once latched
    task automatic lbXfer(input logic wr, input logic [31:0] wd, input int hold, output logic [31:0] rd);
        tick();
        addrStrobeN = 1'b1;
        cycleQualifierN = 1'b0;
        syncDir = wr;
        dataIn = wd;
        tick();
        cycleQualifierN = 1'b1;
        addrIn = ~addrIn;
        addrSpaceEnable = 1'b1;
        for (int n = 0; n < 64 && syncReadyN !== 1'b0; n++) tick();
        rd = dataOut;
        repeat (hold) tick();
        readyReturnN = 1'b0;
        tick();
        readyReturnN = 1'b1;
        syncDir = 1'b0;
        addrStrobeN = 1'b0;
        dataIn = ~wd;
        tick();
    endtask
    // one burst beat, selects left asserted for the next beat
    task automatic burstBeat(input logic wr, input logic [31:0] wd, input int hostWait, output logic [31:0] rd);
        queuePortSelectN = 1'b0;
        dataIn = wd;
        if (wr) cycleQualifierN = 1'b0;
        else syncDir = 1'b0;
        for (int n = 0; n < 64 && syncReadyN !== 1'b0; n++) tick();
        for (int n = 0; n < 64 && syncReadyN !== 1'b1; n++) tick();
        rd = dataOut;
        if (hostWait > 0) readyReturnN = 1'b0;
        repeat (hostWait) tick();
        readyReturnN = 1'b1;
        tick();
    endtask
    task automatic burstEnd();
        queuePortSelectN = 1'b1;
        cycleQualifierN = 1'b1;
        syncDir = 1'b1;
        tick();
    endtask
endmodule // hbiu_host_model
`default_nettype wire

// *** testbench/hbiu_host_port_bench.sv ***
// hbiu_host_port_bench: self-checking bench with host model and core responder
// assumes design, checker and host model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samplesChecked++; if ((a) !== (e)) begin errCount++; \
    $display("mismatch %s exp %h got %h", n, e, a); end end
module hbiu_host_port_bench;
    localparam logic [15:4] BASE = 12'h3A5;
    logic clk_sys = 1'b0, rst = 1'b1, syncStyleStrap = 1'b0, reqAck = 1'b0;
    logic [31:0] reqRdData = 32'h0, dataIn, dataOut, reqWrData, lastWd, lastRd;
    logic [15:1] addrIn;
    logic [3:0] lanesN, reqLanes;
    logic addrSpaceEnable, addrStrobeN, queuePortSelectN, cycleQualifierN, syncDir, readyReturnN, asyncRdN, asyncWrN;
    logic localTargetHitN, syncReadyN, asyncWaitN, dataOe, reqValid, reqWrite, reqQueue;
    logic [2:0] reqOffset;
    logic [1:0] reqSize;
    logic [10:0] lastReq;
    int reqCount = 0, errCount = 0, samplesChecked = 0;
    ////////////////////////////////////////////////////////////
    hbiu_host_port uut (.clk_sys, .rst, .addrIn, .addrSpaceEnable, .lane0SelN(lanesN[0]), .lane1SelN(lanesN[1]),
        .lane2SelN(lanesN[2]), .lane3SelN(lanesN[3]), .addrStrobeN, .queuePortSelectN, .baseAddr(BASE),
        .localTargetHitN, .syncStyleStrap, .cycleQualifierN, .syncDir, .syncReadyN, .readyReturnN, .asyncRdN,
        .asyncWrN, .asyncWaitN, .dataIn, .dataOut, .dataOe, .reqValid, .reqWrite, .reqQueue, .reqOffset, .reqLanes,
        .reqSize, .reqWrData, .reqAck, .reqRdData);
    hbiu_host_model host (.clk_sys, .addrIn, .addrSpaceEnable, .lanesN, .addrStrobeN, .queuePortSelectN,
        .cycleQualifierN, .syncDir, .readyReturnN, .asyncRdN, .asyncWrN, .dataIn, .syncReadyN, .asyncWaitN, .dataOut);
    initial forever #10 clk_sys = ~clk_sys;
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    function automatic logic [1:0] expSize(input logic [3:0] l);
        case (l)
            4'h0: return hbiu_pkg::SIZE_WORD;
            4'h3, 4'hC: return hbiu_pkg::SIZE_HALF;
            4'h7, 4'hB, 4'hD, 4'hE: return hbiu_pkg::SIZE_BYTE;
            default: return hbiu_pkg::SIZE_BAD;
        endcase
    endfunction
    task automatic chkReq(input int c, input logic wr, input logic q, input logic [15:1] a, input logic [3:0] ln,
            input logic [31:0] wd, input logic [31:0] rd);
        logic [3:0] el;
        el = q ? hbiu_pkg::LANES_WORD : ln;
        `CHK("reqCount", c + 1, reqCount)
        `CHK("request", {wr, q, q ? hbiu_pkg::QUEUE_OFFSET : a[3:1], el, expSize(el)}, lastReq)
        if (wr) `CHK("writeData", wd, lastWd)
        else `CHK("readData", lastRd, rd)
    endtask
    task automatic finishTest();
        $display("checked %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // core side: acknowledges each request after a random delay
    initial forever begin
        tick();
        if (reqValid === 1'b1) begin
            reqCount++;
            lastReq = {reqWrite, reqQueue, reqOffset, reqLanes, reqSize};
            lastWd = reqWrData;
            repeat (1 + $urandom % 4) tick();
            reqAck = 1'b1;
            reqRdData = $urandom;
            lastRd = reqRdData;
            tick();
            reqAck = 1'b0;
            reqRdData = ~lastRd;
        end
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        errCount++;
        finishTest();
    end
    initial begin
        logic [31:0] rd, wd;
        logic [15:1] a;
        logic [3:0] ln;
        logic wr, q;
        int c;
        void'($urandom(32'hD198));
        repeat (5) tick();
        `CHK("resetOuts", 5'h18, {syncReadyN, asyncWaitN, dataOe, reqValid, |dataOut})
        rst = 1'b0;
        repeat (4) tick();
        for (int i = 0; i < 16; i++) begin
            q = (i % 6 == 5);
            a = {q ? ~BASE : BASE, 3'($urandom)};
            ln = 4'(i);
            wr = 1'($urandom);
            host.setup(a, 1'b0, ln, !q);
            c = reqCount;
            wd = $urandom;
            host.asyncXfer(wr, wd, rd);
            chkReq(c, wr, q, a, ln, wd, rd);
        end
        for (int i = 0; i < 2; i++) begin
            host.setup({i ? ~BASE : BASE, 3'h1}, i == 0, 4'h0, 1'b1);
            c = reqCount;
            host.asyncXfer(1'b1, 32'h0, rd);
            `CHK("missCount", c, reqCount)
        end
        for (int i = 0; i < 10; i++) begin
            q = (i == 9);
            a = {q ? ~BASE : BASE, 3'($urandom)};
            ln = 4'($urandom);
            wr = 1'($urandom);
            host.setup(a, 1'b0, ln, !q);
            c = reqCount;
            wd = $urandom;
            host.lbXfer(wr, wd, $urandom % 3, rd);
            if (q) `CHK("lbQueue", c, reqCount)
            else chkReq(c, wr, 1'b0, a, ln, wd, rd);
        end
        host.burstEnd();
        syncStyleStrap = 1'b1;
        a = {~BASE, 3'h5};
        host.setup(a, 1'b1, 4'hA, 1'b1);
        repeat (4) tick();
        for (int i = 0; i < 8; i++) begin
            wr = (i >= 4);
            if (i == 4) host.burstEnd();
            c = reqCount;
            wd = $urandom;
            host.burstBeat(wr, wd, $urandom % 3, rd);
            chkReq(c, wr, 1'b1, a, 4'hA, wd, rd);
        end
        host.burstEnd();
        finishTest();
    end
endmodule // hbiu_host_port_bench
`default_nettype wire
